//--- core/bst_pkg.sv
// Shared constants and types for the boundary-scan test access port.
// Assumes a single system clock that oversamples the test clock pin.
package bst_pkg;

   // Register widths
   localparam int IR_WIDTH  = 8;
   localparam int BCR_WIDTH = 2;
   localparam int BSR_WIDTH = 18;

   // Reset and capture values
   localparam logic [IR_WIDTH-1:0]  IR_RESET       = 8'hFF;
   localparam logic [IR_WIDTH-1:0]  IR_CAPTURE     = 8'h81;
   localparam logic [BCR_WIDTH-1:0] BCR_RESET      = 2'h2;
   localparam logic                 BYPASS_CAPTURE = 1'h0;

   // Timing counts, in test clock rising edges
   localparam int TMS_RESET_EDGES = 5;

   // Opcode field, bit 7 is never decoded
   localparam int OPC_MSB = 6;
   localparam logic [OPC_MSB:0] OPC_EXTEST  = 7'h00;
   localparam logic [OPC_MSB:0] OPC_SAMPLE  = 7'h02;
   localparam logic [OPC_MSB:0] OPC_INTEST  = 7'h03;
   localparam logic [OPC_MSB:0] OPC_HIGHZ   = 7'h06;
   localparam logic [OPC_MSB:0] OPC_CLAMP   = 7'h07;
   localparam logic [OPC_MSB:0] OPC_RUNT    = 7'h09;
   localparam logic [OPC_MSB:0] OPC_READBN  = 7'h0A;
   localparam logic [OPC_MSB:0] OPC_READBT  = 7'h0B;
   localparam logic [OPC_MSB:0] OPC_CELLTST = 7'h0C;
   localparam logic [OPC_MSB:0] OPC_TOGGLE  = 7'h0D;
   localparam logic [OPC_MSB:0] OPC_SCANCN  = 7'h0E;
   localparam logic [OPC_MSB:0] OPC_SCANCT  = 7'h0F;

   // Controller states
   typedef enum logic [3:0] {
      TEST_LOGIC_RESET, RUN_IDLE,
      SELECT_DR, CAPTURE_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR, UPDATE_DR,
      SELECT_IR, CAPTURE_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR, UPDATE_IR
   } bst_state_t;

   // Data register in the scan path
   typedef enum logic [1:0] {SEL_BYPASS, SEL_BOUNDARY, SEL_CONTROL} bst_sel_t;

endpackage : bst_pkg

//--- core/bst_pin_sync.sv
// Three-stage synchroniser with agreement filter for asynchronous pins.
// Assumes pins change far slower than clk; edges are one-cycle pulses.
`timescale 1ns/1ns
module bst_pin_sync #(
   parameter int W = 1
) (
   // System
   input  wire logic         clk,
   input  wire logic         rst,
   // Pins
   input  wire logic [W-1:0] pinAsync,
   // Filtered view
   output logic      [W-1:0] level,
   output logic      [W-1:0] rise,
   output logic      [W-1:0] fall
);

   logic [W-1:0] stage1;
   logic [W-1:0] stage2;
   logic [W-1:0] stage3;
   logic [W-1:0] agree;

   // Pin capture chain; stage1 feeds only stage2
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         stage1 <= '0;
         stage2 <= '0;
         stage3 <= '0;
      end else begin
         stage1 <= pinAsync;
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end

   // A change counts once the two later stages agree
   assign agree = ~(stage2 ^ stage3);
   assign rise  = agree & stage3 & ~level;
   assign fall  = agree & ~stage3 & level;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         level <= '0;
      end else begin
         level <= (agree & stage3) | (~agree & level);
      end
   end

endmodule : bst_pin_sync

//--- core/bst_shift_reg.sv
// Test register: serial shift stage with a shadow latch on every bit.
// Assumes capture, shift and update are one-cycle pulses already aligned to test clock edges.
`timescale 1ns/1ns
module bst_shift_reg #(
   parameter int             W         = 8,
   parameter logic [W-1:0]   RESET_VAL = '0
) (
   // System
   input  wire logic         clk,
   input  wire logic         rst,
   // Strobes
   input  wire logic         clear,
   input  wire logic         capture,
   input  wire logic         shift,
   input  wire logic         update,
   // Data
   input  wire logic         serialIn,
   input  wire logic [W-1:0] captureData,
   output logic      [W-1:0] shiftQ,
   output logic      [W-1:0] shadowQ
);

   // Shift stage, new bits enter at the top and leave at bit 0
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         shiftQ <= RESET_VAL;
      end else if (clear) begin
         shiftQ <= RESET_VAL;
      end else if (capture) begin
         shiftQ <= captureData;
      end else if (shift) begin
         shiftQ <= {serialIn, shiftQ[W-1:1]};
      end
   end

   // Shadow stage, moves only on update or clear so scans never glitch outputs
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         shadowQ <= RESET_VAL;
      end else if (clear) begin
         shadowQ <= RESET_VAL;
      end else if (update) begin
         shadowQ <= shiftQ;
      end
   end

endmodule : bst_shift_reg

//--- core/bst_tap.sv
// Boundary-scan test access port controller with its test registers.
// Assumes test pins are asynchronous to clk and the test clock is much slower.
`timescale 1ns/1ns

module bst_tap
   import bst_pkg::*;
(
   // System
   input  wire logic                 clk,
   input  wire logic                 rst,
   // Test pins
   input  wire logic                 tck,
   input  wire logic                 tms,
   input  wire logic                 tdi,
   output logic                      tdo,
   output logic                      tdoOe,
   // Boundary cells
   input  wire logic [BSR_WIDTH-1:0] bsrCaptureData,
   output logic      [BSR_WIDTH-1:0] bsrUpdate,
   // Status towards the device core
   output logic      [IR_WIDTH-1:0]  instruction,
   output logic      [BCR_WIDTH-1:0] testOpSelect,
   output logic                      testMode,
   output logic                      runTestActive,
   output logic                      logicInReset
);

   ////////////////////////////////////////////////////////////////////////////
   // Decode helpers

   // Data register chosen by an opcode; bit 7 never looked at
   function automatic bst_sel_t decodeSel(input logic [IR_WIDTH-1:0] op);
      unique case (op[OPC_MSB:0])
         OPC_EXTEST, OPC_SAMPLE, OPC_INTEST, OPC_READBN,
         OPC_READBT, OPC_CELLTST:  decodeSel = SEL_BOUNDARY;
         OPC_SCANCN, OPC_SCANCT:   decodeSel = SEL_CONTROL;
         default:                  decodeSel = SEL_BYPASS;
      endcase
   endfunction : decodeSel

   // Test mode versus normal mode for an opcode
   function automatic logic decodeTest(input logic [IR_WIDTH-1:0] op);
      unique case (op[OPC_MSB:0])
         OPC_EXTEST, OPC_INTEST, OPC_HIGHZ, OPC_CLAMP, OPC_RUNT,
         OPC_READBT, OPC_TOGGLE, OPC_SCANCT: decodeTest = 1'b1;
         default:                            decodeTest = 1'b0;
      endcase
   endfunction : decodeTest

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisation

   logic [2:0] pinLevel;
   logic [2:0] pinRise;
   logic [2:0] pinFall;
   logic       tckRise;
   logic       tckFall;
   logic       tmsLvl;
   logic       tdiLvl;

   bst_pin_sync #(.W(3)) u_sync (
      .clk      (clk),
      .rst      (rst),
      .pinAsync ({tdi, tms, tck}),
      .level    (pinLevel),
      .rise     (pinRise),
      .fall     (pinFall)
   );

   assign tckRise = pinRise[0];
   assign tckFall = pinFall[0];
   assign tmsLvl  = pinLevel[1];
   assign tdiLvl  = pinLevel[2];

   ////////////////////////////////////////////////////////////////////////////
   // Controller state machine

   bst_state_t state;
   bst_state_t next_state;

   // Transition table; six states loop on themselves
   always_comb begin
      unique case (state)
         TEST_LOGIC_RESET: next_state = tmsLvl ? TEST_LOGIC_RESET : RUN_IDLE;
         RUN_IDLE:   next_state = tmsLvl ? SELECT_DR  : RUN_IDLE;
         SELECT_DR:  next_state = tmsLvl ? SELECT_IR  : CAPTURE_DR;
         CAPTURE_DR: next_state = tmsLvl ? EXIT1_DR   : SHIFT_DR;
         SHIFT_DR:   next_state = tmsLvl ? EXIT1_DR   : SHIFT_DR;
         EXIT1_DR:   next_state = tmsLvl ? UPDATE_DR  : PAUSE_DR;
         PAUSE_DR:   next_state = tmsLvl ? EXIT2_DR   : PAUSE_DR;
         EXIT2_DR:   next_state = tmsLvl ? UPDATE_DR  : SHIFT_DR;
         UPDATE_DR:  next_state = tmsLvl ? SELECT_DR  : RUN_IDLE;
         SELECT_IR:  next_state = tmsLvl ? TEST_LOGIC_RESET : CAPTURE_IR;
         CAPTURE_IR: next_state = tmsLvl ? EXIT1_IR   : SHIFT_IR;
         SHIFT_IR:   next_state = tmsLvl ? EXIT1_IR   : SHIFT_IR;
         EXIT1_IR:   next_state = tmsLvl ? UPDATE_IR  : PAUSE_IR;
         PAUSE_IR:   next_state = tmsLvl ? EXIT2_IR   : PAUSE_IR;
         EXIT2_IR:   next_state = tmsLvl ? UPDATE_IR  : SHIFT_IR;
         UPDATE_IR:  next_state = tmsLvl ? SELECT_DR  : RUN_IDLE;
      endcase
   end

   // Power-up lands in the reset state; moves only on a rising edge
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state <= TEST_LOGIC_RESET;
      end else if (tckRise) begin
         state <= next_state;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Test registers

   logic                 inReset;
   bst_sel_t             sel;
   logic [IR_WIDTH-1:0]  irShift;
   logic [BCR_WIDTH-1:0] bcrShift;
   logic [BSR_WIDTH-1:0] bsrShift;
   logic                 bypassBit;
   logic                 capDr;
   logic                 shDr;
   logic                 updDr;

   assign inReset = (state == TEST_LOGIC_RESET);
   assign sel     = decodeSel(instruction);
   // Capture and shift act on the rising edge that leaves the state
   assign capDr   = tckRise && state == CAPTURE_DR;
   assign shDr    = tckRise && state == SHIFT_DR;
   assign updDr   = tckFall && state == UPDATE_DR;

   // Instruction register; reset state reloads all ones every cycle
   bst_shift_reg #(.W(IR_WIDTH), .RESET_VAL(IR_RESET)) u_ir (
      .clk         (clk),
      .rst         (rst),
      .clear       (inReset),
      .capture     (tckRise && state == CAPTURE_IR),
      .shift       (tckRise && state == SHIFT_IR),
      .update      (tckFall && state == UPDATE_IR),
      .serialIn    (tdiLvl),
      .captureData (IR_CAPTURE),
      .shiftQ      (irShift),
      .shadowQ     (instruction)
   );

   // Test-operation select register; its capture leaves contents alone
   bst_shift_reg #(.W(BCR_WIDTH), .RESET_VAL(BCR_RESET)) u_bcr (
      .clk         (clk),
      .rst         (rst),
      .clear       (inReset),
      .capture     (1'b0),
      .shift       (shDr && sel == SEL_CONTROL),
      .update      (updDr && sel == SEL_CONTROL),
      .serialIn    (tdiLvl),
      .captureData (BCR_RESET),
      .shiftQ      (bcrShift),
      .shadowQ     (testOpSelect)
   );

   // Boundary register; untouched by the reset state
   bst_shift_reg #(.W(BSR_WIDTH), .RESET_VAL('0)) u_bsr (
      .clk         (clk),
      .rst         (rst),
      .clear       (1'b0),
      .capture     (capDr && sel == SEL_BOUNDARY),
      .shift       (shDr && sel == SEL_BOUNDARY),
      .update      (updDr && sel == SEL_BOUNDARY),
      .serialIn    (tdiLvl),
      .captureData (bsrCaptureData),
      .shiftQ      (bsrShift),
      .shadowQ     (bsrUpdate)
   );

   // Bypass bit: shift stage only, no shadow
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         bypassBit <= BYPASS_CAPTURE;
      end else if (capDr && sel == SEL_BYPASS) begin
         bypassBit <= BYPASS_CAPTURE;
      end else if (shDr && sel == SEL_BYPASS) begin
         bypassBit <= tdiLvl;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Serial output, changes only on falling edges

   logic scanOut;

   // Bit 0 of whatever sits in the scan path
   always_comb begin
      if (state == SHIFT_IR) begin
         scanOut = irShift[0];
      end else begin
         unique case (sel)
            SEL_BOUNDARY: scanOut = bsrShift[0];
            SEL_CONTROL:  scanOut = bcrShift[0];
            default:      scanOut = bypassBit;
         endcase
      end
   end

   // Enable follows the shift states; Exit1 releases it a half cycle later
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tdoOe <= 1'b0;
         tdo   <= 1'b0;
      end else if (tckFall) begin
         tdoOe <= (state == SHIFT_DR) || (state == SHIFT_IR);
         tdo   <= scanOut;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Mode and status outputs

   // Mode flips only after the new instruction reaches the shadow stage
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         testMode      <= 1'b0;
         runTestActive <= 1'b0;
         logicInReset  <= 1'b1;
      end else begin
         testMode      <= decodeTest(instruction) && !inReset;
         runTestActive <= state == RUN_IDLE
                          && instruction[OPC_MSB:0] == OPC_RUNT;
         logicInReset  <= inReset;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   // Consecutive rising edges seen with mode select high
   logic [2:0] tmsHighCnt;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tmsHighCnt <= '0;
      end else if (tckRise) begin
         if (!tmsLvl) begin
            tmsHighCnt <= '0;
         end else if (tmsHighCnt < 3'(TMS_RESET_EDGES)) begin
            tmsHighCnt <= tmsHighCnt + 3'h1;
         end
      end
   end

   sequence riseIn(bst_state_t st);
      tckRise && state == st;
   endsequence

   sequence fallIn(bst_state_t st);
      tckFall && state == st;
   endsequence

   chk_state_still: assert property (@(posedge clk) disable iff (rst)
      !tckRise |=> state == $past(state))
      else $error("state moved without a test clock rising edge");

   chk_tms_reset: assert property (@(posedge clk) disable iff (rst)
      tmsHighCnt == 3'(TMS_RESET_EDGES) |-> state == TEST_LOGIC_RESET)
      else $error("five high mode edges did not reach reset");

   chk_ir_reset: assert property (@(posedge clk) disable iff (rst)
      inReset |=> instruction == IR_RESET && irShift == IR_RESET)
      else $error("instruction not all ones in reset state");

   chk_bcr_reset: assert property (@(posedge clk) disable iff (rst)
      inReset |=> testOpSelect == BCR_RESET)
      else $error("test-operation select not reset to 10");

   chk_select_leave: assert property (@(posedge clk) disable iff (rst)
      riseIn(SELECT_DR) or riseIn(SELECT_IR)
      |=> state != $past(state))
      else $error("select state held across a rising edge");

   chk_capture_ir: assert property (@(posedge clk) disable iff (rst)
      riseIn(CAPTURE_IR) |=> irShift == IR_CAPTURE)
      else $error("capture-IR pattern wrong");

   chk_bypass_zero: assert property (@(posedge clk) disable iff (rst)
      riseIn(CAPTURE_DR) ##0 (sel == SEL_BYPASS) |=> !bypassBit)
      else $error("bypass bit did not capture zero");

   chk_tdo_enable: assert property (@(posedge clk) disable iff (rst)
      fallIn(SHIFT_DR) or fallIn(SHIFT_IR) |=> tdoOe && tdo == $past(scanOut))
      else $error("data out not enabled in shift state");

   chk_tdo_release: assert property (@(posedge clk) disable iff (rst)
      fallIn(EXIT1_DR) or fallIn(EXIT1_IR) |=> !tdoOe)
      else $error("data out still driven after exit");

   chk_pause_hold: assert property (@(posedge clk) disable iff (rst)
      state == PAUSE_IR && $past(state) == PAUSE_IR |-> $stable(irShift))
      else $error("instruction shift stage changed in pause");

   chk_run_idle: assert property (@(posedge clk) disable iff (rst)
      runTestActive |-> $past(state) == RUN_IDLE)
      else $error("test operation active outside run/idle");

endmodule : bst_tap

//--- tb/bst_jtag_host.sv
// Scan host model: drives the test clock, mode select and serial data pins.
// Assumes each step is entered at a falling clk edge; one test clock is 8 clk.
`timescale 1ns/1ns
module bst_jtag_host (
   // System
   input  wire logic       clk,
   // Test pins
   output logic            tck,
   output logic            tms,
   output logic            tdi,
   input  wire logic       tdo,
   input  wire logic       tdoOe,
   // Sample report
   output logic            sampleStrobe,
   output logic [1:0]      sampleLevel
);

   ////////////////////////////////////////////////////////////////////////////
   // Idle pins: clock stands low, select and data sit at pull-up level
   initial begin
      tck          = 1'b0;
      tms          = 1'b1;
      tdi          = 1'b1;
      sampleStrobe = 1'b0;
      sampleLevel  = 2'b00;
   end

   ////////////////////////////////////////////////////////////////////////////
   // One test clock; pins move at the test clock fall so they are settled
   // for four clk before the rise, where the pin filter needs only one
   task automatic step(input logic m, input logic d);
      tms = m;
      tdi = d;
      repeat (4) @(negedge clk);
      tck = 1'b1;
      repeat (3) @(negedge clk);
      // Pull-up decides the wire while the output is off
      sampleLevel  = {tdoOe, tdoOe ? tdo : 1'b1};
      sampleStrobe = 1'b1;
      @(negedge clk);
      sampleStrobe = 1'b0;
      tck          = 1'b0;
   endtask : step

endmodule : bst_jtag_host

//--- tb/test_bst_tap.sv
// Self-checking bench for the access port controller and its test registers.
// Assumes the host model owns all test pin timing; register checks run on clk.
`timescale 1ns/1ns
module test_bst_tap
   import bst_pkg::*;
;

`define CHK(nm, e, g) begin nChecks++; if ((g) !== (e)) begin badCount++; \
   $display("unexpected %s expected %h seen %h", nm, e, g); end end

   logic                 clk, rst, tck, tms, tdi, tdo, tdoOe, sampleStrobe;
   logic                 testMode, runTestActive, logicInReset;
   logic [1:0]           sampleLevel, expNow, ctlShift;
   logic [BSR_WIDTH-1:0] bsrCaptureData, bsrUpdate;
   logic [IR_WIDTH-1:0]  instruction, op;
   logic [BCR_WIDTH-1:0] testOpSelect;
   logic [1:0]           expQ[$];
   logic [31:0]          lfsr = 32'he65f_eccc;
   int                   badCount = 0;
   int                   nChecks = 0;
   int                   k, w;

   ////////////////////////////////////////////////////////////////////////////
   // Clock at 25 MHz
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   bst_tap bst_tap_inst (.clk(clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi),
      .tdo(tdo), .tdoOe(tdoOe), .bsrCaptureData(bsrCaptureData), .bsrUpdate(bsrUpdate),
      .instruction(instruction), .testOpSelect(testOpSelect), .testMode(testMode),
      .runTestActive(runTestActive), .logicInReset(logicInReset));

   bst_jtag_host bst_jtag_host_inst (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi),
      .tdo(tdo), .tdoOe(tdoOe), .sampleStrobe(sampleStrobe), .sampleLevel(sampleLevel));

   ////////////////////////////////////////////////////////////////////////////
   // Helpers
   function automatic logic [31:0] nextRand(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : nextRand

   function automatic int drWidth(input logic [7:0] o);
      if (o[6:0] inside {7'h00, 7'h02, 7'h03, 7'h0A, 7'h0B, 7'h0C}) return BSR_WIDTH;
      return (o[6:0] inside {7'h0E, 7'h0F}) ? BCR_WIDTH : 1;
   endfunction : drWidth

   function automatic logic testModeOf(input logic [7:0] o);
      return o[6:0] inside {7'h00, 7'h03, 7'h06, 7'h07, 7'h09, 7'h0B, 7'h0D, 7'h0F};
   endfunction : testModeOf

   // Note the pin level the host should see, then run one test clock
   task automatic go(input logic m, input logic d, input logic [1:0] e);
      expQ.push_back(e);
      bst_jtag_host_inst.step(m, d);
   endtask : go

   // Scan from run/idle back to run/idle; p > 0 parks in pause after p bits
   task automatic scan(input logic ir, input int n, input int wd, input logic [31:0] cap,
                       input logic [31:0] din, input int p);
      int i;
      go(1'b1, 1'b1, 2'b01);
      if (ir) go(1'b1, 1'b1, 2'b01);
      go(1'b0, 1'b1, 2'b01);
      go(1'b0, 1'b1, 2'b01);
      for (i = 0; i < n; i++) begin
         go(i == n - 1 || i == p - 1, din[i], {1'b1, i < wd ? cap[i] : din[i - wd]});
         if (i == p - 1) begin
            // Long pause must neither shift nor recapture
            repeat (4) go(1'b0, 1'b1, 2'b01);
            go(1'b1, 1'b1, 2'b01);
            go(1'b0, 1'b1, 2'b01);
         end
      end
      go(1'b1, 1'b1, 2'b01);
      go(1'b0, 1'b1, 2'b01);
      repeat (8) @(negedge clk);
   endtask : scan

   task automatic giveVerdict();
      $display("checks %0d mismatches %0d", nChecks, badCount);
      if (badCount == 0 && nChecks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : giveVerdict

   ////////////////////////////////////////////////////////////////////////////
   // Oldest note against each host sample of the data out wire
   always @(posedge clk) begin
      if (sampleStrobe === 1'b1) begin
         if (expQ.size() == 0) begin
            badCount++;
            $display("unexpected tdo wire expected none seen %h", sampleLevel);
         end else begin
            expNow = expQ.pop_front();
            `CHK("tdo wire", expNow, sampleLevel)
         end
      end
   end

   // Watchdog, about four times the expected run
   initial begin
      #1_000_000;
      badCount++;
      giveVerdict();
   end

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      rst            = 1'b1;
      bsrCaptureData = '0;
      ctlShift       = 2'b10;
      repeat (12) @(negedge clk);
      rst = 1'b0;
      repeat (2) @(negedge clk);
      `CHK("in reset", 1'b1, logicInReset)
      `CHK("instruction", 8'hFF, instruction)
      `CHK("op select", 2'b10, testOpSelect)
      `CHK("test mode", 1'b0, testMode)
      go(1'b0, 1'b1, 2'b01);
      repeat (8) @(negedge clk);
      `CHK("in reset", 1'b0, logicInReset)
      lfsr = nextRand(lfsr);
      scan(1'b0, 6, 1, 32'h0, lfsr, 3);
      // Every opcode, bit 7 random, then a scan of the register it selects
      for (k = 0; k < 16; k++) begin
         lfsr = nextRand(lfsr);
         op   = {lfsr[7], 7'(k)};
         scan(1'b1, 8, 8, 32'h81, 32'(op), 3);
         `CHK("instruction", op, instruction)
         `CHK("test mode", testModeOf(op), testMode)
         w              = drWidth(op);
         bsrCaptureData = lfsr[31:14];
         lfsr           = nextRand(nextRand(lfsr));
         scan(1'b0, w + 3, w, w == 18 ? 32'(bsrCaptureData) : w == 2 ? 32'(ctlShift) : 32'h0,
              lfsr, 2);
         if (w == 18) `CHK("boundary", lfsr[20:3], bsrUpdate)
         if (w == 2) begin
            `CHK("op select", lfsr[4:3], testOpSelect)
            ctlShift = lfsr[4:3];
         end
         `CHK("run test", k == 9, runTestActive)
      end
      // Run test active only in run/idle; then five highs from shift-DR
      scan(1'b1, 8, 8, 32'h81, 32'h89, 0);
      `CHK("run test", 1'b1, runTestActive)
      go(1'b1, 1'b1, 2'b01);
      repeat (8) @(negedge clk);
      `CHK("run test", 1'b0, runTestActive)
      go(1'b0, 1'b1, 2'b01);
      go(1'b0, 1'b1, 2'b01);
      go(1'b1, 1'b1, 2'b10);
      repeat (4) go(1'b1, 1'b1, 2'b01);
      repeat (8) @(negedge clk);
      `CHK("in reset", 1'b1, logicInReset)
      `CHK("instruction", 8'hFF, instruction)
      `CHK("op select", 2'b10, testOpSelect)
      `CHK("test mode", 1'b0, testMode)
      `CHK("notes left", 0, expQ.size())
      giveVerdict();
   end

endmodule : test_bst_tap
